// ---- hdl/ros_pkg.sv ----
// ros_pkg: constants and carrier types for the relay override and motion supervisor
// assumes a 50 MHz system clock; registers reached over AXI4-Lite with 32-bit data
package ros_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int PULSE_MIN_US = 50;
	localparam int LEVEL_MIN_MS = 2;
	localparam int PULSE_CYC = (PULSE_MIN_US * (CLK_HZ / 1_000_000));
	localparam int LEVEL_CYC = (LEVEL_MIN_MS * (CLK_HZ / 1_000));
	localparam int TICK_CYC = CLK_HZ / 1_000;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FUNC = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] OFS_TIME = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	// field positions in CTRL
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_PAT_LSB = 4;
	localparam int CTRL_POL_BIT = 8;
	// field positions in FUNC
	localparam int FUNC_UP_LSB = 0;
	localparam int FUNC_IN1_LSB = 8;
	localparam int FUNC_IN2_LSB = 16;
	// field positions in TIME
	localparam int TIME_START_LSB = 0;
	localparam int TIME_STILL_LSB = 16;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] FUNC_RST = 32'h0000_0000;
	localparam logic [31:0] MODE_RST = 32'h0000_0001;
	localparam logic [31:0] TIME_RST = 32'h03E8_01F4;
	// codes
	localparam logic [3:0] SEL_FREEZE = 4'h8;
	localparam logic [7:0] FN_OVERRIDE = 8'h02;
	localparam logic [7:0] FN_CMDMON = 8'h0C;
	localparam logic [1:0] MODE_OVER = 2'h0;
	localparam logic [1:0] MODE_UNDER = 2'h1;
	localparam logic [1:0] AXI_OKAY = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		MON_IDLE = 2'b00,
		MON_RUN = 2'b01,
		MON_STOP = 2'b10
	} ros_mon_type;

	typedef struct packed {
		logic awValid;
		logic [7:0] awAddr;
		logic wValid;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bReady;
		logic arValid;
		logic [7:0] arAddr;
		logic rReady;
	} ros_axi_req_type;

	typedef struct packed {
		logic awReady;
		logic wReady;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} ros_axi_rsp_type;
endpackage

// ---- hdl/ros_relay_supervisor.sv ----
// ros_relay_supervisor: relay override/freeze and remote enable command monitor
// assumes pins and keys are asynchronous; monitoring demands and speed flags arrive on clk_sys
`timescale 1ns/100ps
`default_nettype none
module ros_relay_supervisor #(
	parameter int LEVEL_CYCLES = ros_pkg::LEVEL_CYC,
	parameter int TICK_CYCLES = ros_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// register bus
	input wire ros_pkg::ros_axi_req_type axiReq,
	output ros_pkg::ros_axi_rsp_type axiRsp,
	// keys and remote inputs
	input wire logic keyUp,
	input wire logic remote_input_one,
	input wire logic remoteInputTwo,
	// monitoring results
	input wire logic [2:0] relayDemand,
	input wire logic speedZero,
	input wire logic standstill,
	// relays and status
	output logic relay_out_one,
	output logic relay_out_two,
	output logic relay_out_three,
	output logic motionDisabled,
	output logic cmdAlarm,
	output logic pulseSeen
);
	localparam int LW = $clog2(LEVEL_CYCLES + 1);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int PW = $clog2(ros_pkg::PULSE_CYC + 1);

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] func;
		logic [31:0] mode;
		logic [31:0] timing;
		logic [2:0] syncA;
		logic [2:0] syncB;
		logic [2:0] level;
		logic [2:0][LW-1:0] filt;
		logic [PW-1:0] pulseCnt;
		logic pulseSeen;
		logic [2:0] frozen;
		logic frzActive;
		logic [2:0] relays;
		ros_pkg::ros_mon_type mon;
		logic [TW-1:0] tick;
		logic [15:0] msCnt;
		logic alarm;
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} ros_state_type;

	ros_state_type state_ff;
	ros_state_type nxt_state;

	function automatic logic [31:0] ros_merge(input logic [31:0] old, input logic [31:0] din,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = din[b*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [3:0] sel;
	logic [2:0] pat;
	logic inPol;
	logic [7:0] fnUp;
	logic [7:0] fnIn1;
	logic [7:0] fnIn2;
	logic [15:0] startDelay;
	logic [15:0] stillTime;
	logic monOn;
	logic enableRaw;
	logic enabled;
	logic overrideCmd;
	logic freezeCmd;
	logic [2:0] underMask;
	logic [2:0] overMask;
	logic windowOk;
	logic [2:0] base;
	logic wrDo;
	logic [7:0] rdAddr;

	always_comb begin
		sel = state_ff.ctrl[ros_pkg::CTRL_SEL_LSB +: 4];
		pat = state_ff.ctrl[ros_pkg::CTRL_PAT_LSB +: 3];
		inPol = state_ff.ctrl[ros_pkg::CTRL_POL_BIT];
		fnUp = state_ff.func[ros_pkg::FUNC_UP_LSB +: 8];
		fnIn1 = state_ff.func[ros_pkg::FUNC_IN1_LSB +: 8];
		fnIn2 = state_ff.func[ros_pkg::FUNC_IN2_LSB +: 8];
		startDelay = state_ff.timing[ros_pkg::TIME_START_LSB +: 16];
		stillTime = state_ff.timing[ros_pkg::TIME_STILL_LSB +: 16];
		// relay modes: two bits per relay
		underMask = '0;
		overMask = '0;
		for (int i = 0; i < 3; i++) begin
			underMask[i] = (state_ff.mode[2*i +: 2] == ros_pkg::MODE_UNDER);
			overMask[i] = (state_ff.mode[2*i +: 2] == ros_pkg::MODE_OVER);
		end
		// the speed window needs both a lower and an upper limit relay
		monOn = ((fnIn1 == ros_pkg::FN_CMDMON) || (fnIn2 == ros_pkg::FN_CMDMON))
			&& (underMask != 3'b000)
			&& (overMask != 3'b000);
		enableRaw = (fnIn1 == ros_pkg::FN_CMDMON) ? state_ff.level[1] : state_ff.level[2];
		enabled = enableRaw ^ inPol;
		// triggers are level-qualified inputs
		overrideCmd = (fnUp == ros_pkg::FN_OVERRIDE) && state_ff.level[0]
			&& (sel != ros_pkg::SEL_FREEZE);
		freezeCmd = (((fnIn1 == ros_pkg::FN_OVERRIDE) && state_ff.level[1])
			|| (overrideCmd == 1'b0 && (fnUp == ros_pkg::FN_OVERRIDE) && state_ff.level[0]))
			&& (sel == ros_pkg::SEL_FREEZE);
		windowOk = !speedZero;
		base = relayDemand;
		wrDo = state_ff.awHeld && state_ff.wHeld && !state_ff.bValid;
		rdAddr = axiReq.arAddr;

		nxt_state = state_ff;
		// synchronisers and level filters
		nxt_state.syncA = {remoteInputTwo, remote_input_one, keyUp};
		nxt_state.syncB = state_ff.syncA;
		for (int i = 0; i < 3; i++) begin
			if (state_ff.syncB[i] == state_ff.level[i]) begin
				nxt_state.filt[i] = '0;
			end else if (state_ff.filt[i] >= LW'(LEVEL_CYCLES - 1)) begin
				nxt_state.level[i] = state_ff.syncB[i];
				nxt_state.filt[i] = '0;
			end else begin
				nxt_state.filt[i] = state_ff.filt[i] + LW'(1);
			end
		end
		// edge-pulse qualification on the first remote input
		nxt_state.pulseSeen = 1'b0;
		if (state_ff.syncB[1]) begin
			if (state_ff.pulseCnt != PW'(ros_pkg::PULSE_CYC)) begin
				nxt_state.pulseCnt = state_ff.pulseCnt + PW'(1);
			end
			if (state_ff.pulseCnt == PW'(ros_pkg::PULSE_CYC - 1)) begin
				nxt_state.pulseSeen = 1'b1;
			end
		end else begin
			nxt_state.pulseCnt = '0;
		end
		// millisecond time base
		if (state_ff.tick >= TW'(TICK_CYCLES - 1)) begin
			nxt_state.tick = '0;
		end else begin
			nxt_state.tick = state_ff.tick + TW'(1);
		end
		// command monitor
		// its timer saturates so a long stay never wraps back below a limit
		case (state_ff.mon)
			ros_pkg::MON_IDLE: begin
				nxt_state.alarm = 1'b0;
				nxt_state.msCnt = '0;
				if (monOn) begin
					nxt_state.mon = enabled ? ros_pkg::MON_RUN : ros_pkg::MON_STOP;
				end
			end
			ros_pkg::MON_RUN: begin
				if (!monOn) begin
					nxt_state.mon = ros_pkg::MON_IDLE;
				end else if (!enabled) begin
					nxt_state.mon = ros_pkg::MON_STOP;
					nxt_state.msCnt = '0;
					nxt_state.alarm = 1'b0;
				end else begin
					if (state_ff.tick == '0 && state_ff.msCnt != 16'hFFFF) begin
						nxt_state.msCnt = state_ff.msCnt + 16'h0001;
					end
					if (state_ff.msCnt >= startDelay) begin
						nxt_state.alarm = !windowOk;
					end
				end
			end
			ros_pkg::MON_STOP: begin
				if (!monOn) begin
					nxt_state.mon = ros_pkg::MON_IDLE;
				end else if (enabled) begin
					nxt_state.mon = ros_pkg::MON_RUN;
					nxt_state.msCnt = '0;
					nxt_state.alarm = 1'b0;
				end else begin
					if (state_ff.tick == '0 && state_ff.msCnt != 16'hFFFF) begin
						nxt_state.msCnt = state_ff.msCnt + 16'h0001;
					end
					if (state_ff.msCnt >= stillTime) begin
						nxt_state.alarm = !standstill;
					end
				end
			end
			default: begin
				nxt_state.mon = ros_pkg::MON_IDLE;
			end
		endcase
		// freeze capture at start
		// snapshot is taken from the registered relays, the state the outputs showed
		nxt_state.frzActive = freezeCmd;
		if (freezeCmd && !state_ff.frzActive) begin
			nxt_state.frozen = state_ff.relays;
		end
		// relay selection, evaluation always runs underneath
		for (int i = 0; i < 3; i++) begin
			if (monOn && underMask[i]) begin
				base[i] = relayDemand[i] | state_ff.alarm;
			end
		end
		// freeze outranks override, which yields while the selection asks for freeze
		if (freezeCmd) begin
			nxt_state.relays = state_ff.frzActive ? state_ff.frozen : state_ff.relays;
		end else if (overrideCmd) begin
			for (int i = 0; i < 3; i++) begin
				nxt_state.relays[i] = sel[i] ? pat[i] : base[i];
			end
		end else begin
			nxt_state.relays = base;
		end
		// write channel
		// a second address and data pair may be held while the response waits
		if (axiReq.awValid && !state_ff.awHeld) begin
			nxt_state.awHeld = 1'b1;
			nxt_state.awAddr = axiReq.awAddr;
		end
		if (axiReq.wValid && !state_ff.wHeld) begin
			nxt_state.wHeld = 1'b1;
			nxt_state.wData = axiReq.wData;
			nxt_state.wStrb = axiReq.wStrb;
		end
		if (wrDo) begin
			nxt_state.awHeld = 1'b0;
			nxt_state.wHeld = 1'b0;
			nxt_state.bValid = 1'b1;
			nxt_state.bResp = ros_pkg::AXI_OKAY;
			case (state_ff.awAddr)
				ros_pkg::OFS_CTRL: nxt_state.ctrl = ros_merge(state_ff.ctrl, state_ff.wData,
					state_ff.wStrb);
				ros_pkg::OFS_FUNC: nxt_state.func = ros_merge(state_ff.func, state_ff.wData,
					state_ff.wStrb);
				ros_pkg::OFS_MODE: nxt_state.mode = ros_merge(state_ff.mode, state_ff.wData,
					state_ff.wStrb);
				ros_pkg::OFS_TIME: nxt_state.timing = ros_merge(state_ff.timing, state_ff.wData,
					state_ff.wStrb);
				ros_pkg::OFS_STAT: nxt_state.bResp = ros_pkg::AXI_OKAY;
				default: nxt_state.bResp = ros_pkg::AXI_SLVERR;
			endcase
		end
		if (state_ff.bValid && axiReq.bReady) begin
			nxt_state.bValid = 1'b0;
		end
		// read channel
		if (axiReq.arValid && !state_ff.rValid) begin
			nxt_state.rValid = 1'b1;
			nxt_state.rResp = ros_pkg::AXI_OKAY;
			case (rdAddr)
				ros_pkg::OFS_CTRL: nxt_state.rData = state_ff.ctrl;
				ros_pkg::OFS_FUNC: nxt_state.rData = state_ff.func;
				ros_pkg::OFS_MODE: nxt_state.rData = state_ff.mode;
				ros_pkg::OFS_TIME: nxt_state.rData = state_ff.timing;
				// status: key, freeze, motion disabled, alarm, spare, relays
				ros_pkg::OFS_STAT: nxt_state.rData = {24'h00_0000, state_ff.level[0],
					state_ff.frzActive, monOn && !enabled, state_ff.alarm, 1'b0,
					state_ff.relays};
				default: begin
					nxt_state.rData = 32'h0000_0000;
					nxt_state.rResp = ros_pkg::AXI_SLVERR;
				end
			endcase
		end else if (state_ff.rValid && axiReq.rReady) begin
			nxt_state.rValid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_ff <= '0;
			state_ff.ctrl <= ros_pkg::CTRL_RST;
			state_ff.func <= ros_pkg::FUNC_RST;
			state_ff.mode <= ros_pkg::MODE_RST;
			state_ff.timing <= ros_pkg::TIME_RST;
			state_ff.mon <= ros_pkg::MON_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_comb begin
		axiRsp.awReady = !state_ff.awHeld;
		axiRsp.wReady = !state_ff.wHeld;
		axiRsp.bValid = state_ff.bValid;
		axiRsp.bResp = state_ff.bResp;
		axiRsp.arReady = !state_ff.rValid;
		axiRsp.rValid = state_ff.rValid;
		axiRsp.rData = state_ff.rData;
		axiRsp.rResp = state_ff.rResp;
	end

	assign relay_out_one = state_ff.relays[0];
	assign relay_out_two = state_ff.relays[1];
	assign relay_out_three = state_ff.relays[2];
	assign motionDisabled = (state_ff.mon == ros_pkg::MON_STOP);
	assign cmdAlarm = state_ff.alarm;
	assign pulseSeen = state_ff.pulseSeen;
endmodule // ros_relay_supervisor
`default_nettype wire

// ---- dv/ros_relay_supervisor_sva.sv ----
// ros_relay_supervisor_sva: port checks for bus handshakes and relay supervisor outputs
// assumes it is bound onto ros_relay_supervisor; one clock domain, async active-high reset
`timescale 1ns/100ps
`default_nettype none
module ros_relay_supervisor_sva #(
	parameter int LEVEL_CYCLES = ros_pkg::LEVEL_CYC,
	parameter int TICK_CYCLES = ros_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// register bus
	input wire ros_pkg::ros_axi_req_type axiReq,
	input wire ros_pkg::ros_axi_rsp_type axiRsp,
	// inputs
	input wire logic keyUp,
	input wire logic remote_input_one,
	input wire logic remoteInputTwo,
	input wire logic [2:0] relayDemand,
	input wire logic speedZero,
	input wire logic standstill,
	// outputs
	input wire logic relay_out_one,
	input wire logic relay_out_two,
	input wire logic relay_out_three,
	input wire logic motionDisabled,
	input wire logic cmdAlarm,
	input wire logic pulseSeen
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_wr_taken;
		axiReq.awValid && axiRsp.awReady && axiReq.wValid && axiRsp.wReady && !axiRsp.bValid;
	endsequence
	sequence s_rd_taken;
		axiReq.arValid && axiRsp.arReady;
	endsequence
	property p_wr_answer; s_wr_taken |=> ##1 axiRsp.bValid; endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
	property p_b_hold; axiRsp.bValid && !axiReq.bReady |=> axiRsp.bValid && $stable(axiRsp.bResp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_b_busy; !axiRsp.awReady && !axiRsp.wReady && !axiRsp.bValid |=> axiRsp.bValid;
	endproperty
	a_b_busy: assert property (p_b_busy) else $error("held write not answered");
	property p_rd_answer; s_rd_taken |=> axiRsp.rValid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read data missing");
	property p_r_hold; axiRsp.rValid && !axiReq.rReady |=> axiRsp.rValid && $stable(axiRsp.rData);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_r_busy; axiRsp.rValid |-> !axiRsp.arReady; endproperty
	a_r_busy: assert property (p_r_busy) else $error("read accepted while data pending");
	property p_r_done; axiRsp.rValid && axiReq.rReady |=> !axiRsp.rValid; endproperty
	a_r_done: assert property (p_r_done) else $error("read data repeated");
	property p_pulse; pulseSeen |-> $past(remote_input_one, 8) ##1 !pulseSeen; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse flag wrong");
	property p_reset_quiet;
		disable iff (1'b0) reset |-> !relay_out_one && !relay_out_two && !relay_out_three
			&& !cmdAlarm && !motionDisabled;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
endmodule // ros_relay_supervisor_sva
bind ros_relay_supervisor ros_relay_supervisor_sva #(
	.LEVEL_CYCLES(LEVEL_CYCLES), .TICK_CYCLES(TICK_CYCLES)
) u_sva (
	.clk_sys(clk_sys), .reset(reset), .axiReq(axiReq), .axiRsp(axiRsp), .keyUp(keyUp),
	.remote_input_one(remote_input_one), .remoteInputTwo(remoteInputTwo),
	.relayDemand(relayDemand), .speedZero(speedZero), .standstill(standstill),
	.relay_out_one(relay_out_one), .relay_out_two(relay_out_two),
	.relay_out_three(relay_out_three), .motionDisabled(motionDisabled),
	.cmdAlarm(cmdAlarm), .pulseSeen(pulseSeen)
);
`default_nettype wire

// ---- dv/ros_far_side.sv ----
// ros_far_side: keys, control inputs, remote enable source and measurement flags
// assumes the bench sets wanted levels just after rising edges of clk_sys
`timescale 1ns/100ps
`default_nettype none
module ros_far_side #(
	parameter int HOLD = 8
) (
	// clock
	input wire logic clk_sys,
	// wanted levels, pins bit0 key, bit1 input one, bit2 input two
	input wire logic [2:0] wantPins,
	input wire logic [2:0] wantDemand,
	input wire logic wantZero,
	input wire logic wantStill,
	// toward the block
	output logic keyUp,
	output logic remote_input_one,
	output logic remoteInputTwo,
	output logic [2:0] relayDemand,
	output logic speedZero,
	output logic standstill
);
	int holdCnt;
	initial begin
		{remoteInputTwo, remote_input_one, keyUp} = 3'h0;
		{relayDemand, speedZero, standstill} = 5'h00;
		holdCnt = 0;
	end
	always @(posedge clk_sys) begin
		// levels only, each standing at least HOLD cycles
		if (holdCnt != 0) holdCnt <= holdCnt - 1;
		else if ({remoteInputTwo, remote_input_one, keyUp} != wantPins) begin
			{remoteInputTwo, remote_input_one, keyUp} <= wantPins;
			holdCnt <= HOLD;
		end
		// measurement keeps running whatever the relays show
		relayDemand <= wantDemand;
		speedZero <= wantZero;
		standstill <= wantStill;
	end
endmodule // ros_far_side
`default_nettype wire

// ---- dv/test_relay_override_motion_supervisor.sv ----
// test_relay_override_motion_supervisor: self-checking bench for ros_relay_supervisor
// assumes short filter and tick parameters; far side modelled by ros_far_side
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin nMismatch++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_relay_override_motion_supervisor;
	logic clk_sys, reset, motionDisabled, cmdAlarm, pulseSeen;
	logic keyUp, remote_input_one, remoteInputTwo, speedZero, standstill, wZero, wStill;
	logic [2:0] relays, relayDemand, wPins, wDem, dem, sel, pat;
	logic [1:0] resp;
	logic [31:0] rdat;
	logic [7:0] ofs [4];
	logic [31:0] rv [4];
	ros_pkg::ros_axi_req_type req;
	ros_pkg::ros_axi_rsp_type rsp;
	int nMismatch = 0, totalChecks = 0, pulses = 0;
	ros_far_side #(.HOLD(8)) u_far (.clk_sys(clk_sys), .wantPins(wPins), .wantDemand(wDem),
		.wantZero(wZero), .wantStill(wStill), .keyUp(keyUp), .remote_input_one(remote_input_one),
		.remoteInputTwo(remoteInputTwo), .relayDemand(relayDemand), .speedZero(speedZero),
		.standstill(standstill));
	ros_relay_supervisor #(.LEVEL_CYCLES(8), .TICK_CYCLES(4)) dut (.clk_sys(clk_sys),
		.reset(reset), .axiReq(req), .axiRsp(rsp), .keyUp(keyUp),
		.remote_input_one(remote_input_one), .remoteInputTwo(remoteInputTwo),
		.relayDemand(relayDemand), .speedZero(speedZero), .standstill(standstill),
		.relay_out_one(relays[0]), .relay_out_two(relays[1]), .relay_out_three(relays[2]),
		.motionDisabled(motionDisabled), .cmdAlarm(cmdAlarm), .pulseSeen(pulseSeen));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (pulseSeen === 1'b1) pulses++;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n, dly;
		dly = $urandom % 3;
		n = 0;
		@(posedge clk_sys);
		req.awValid <= 1'b1;
		req.awAddr <= a;
		req.wValid <= 1'b1;
		req.wData <= d;
		req.wStrb <= 4'hF;
		req.bReady <= (dly == 0);
		do begin
			@(posedge clk_sys);
			n++;
			if (req.awValid && rsp.awReady === 1'b1) req.awValid <= 1'b0;
			if (req.wValid && rsp.wReady === 1'b1) req.wValid <= 1'b0;
			if (n == dly) req.bReady <= 1'b1;
		end while (!(rsp.bValid === 1'b1 && req.bReady));
		resp = rsp.bResp;
		req.bReady <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		int n, dly;
		dly = $urandom % 3;
		n = 0;
		@(posedge clk_sys);
		req.arValid <= 1'b1;
		req.arAddr <= a;
		req.rReady <= (dly == 0);
		do begin
			@(posedge clk_sys);
			n++;
			if (req.arValid && rsp.arReady === 1'b1) req.arValid <= 1'b0;
			if (n == dly) req.rReady <= 1'b1;
		end while (!(rsp.rValid === 1'b1 && req.rReady));
		rdat = rsp.rData;
		resp = rsp.rResp;
		req.rReady <= 1'b0;
	endtask
	task automatic results();
		$display("checks=%0d mismatches=%0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#1_000_000;
		nMismatch++;
		results();
	end
	initial begin
		reset = 1'b1;
		req = '0;
		{wPins, wDem, wZero, wStill} = 8'h00;
		ofs = '{ros_pkg::OFS_CTRL, ros_pkg::OFS_FUNC, ros_pkg::OFS_MODE, ros_pkg::OFS_TIME};
		rv = '{ros_pkg::CTRL_RST, ros_pkg::FUNC_RST, ros_pkg::MODE_RST, ros_pkg::TIME_RST};
		void'($urandom(6365));
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(ofs[i]);
			`CHK(rdat, rv[i]);
		end
		rd(8'h14);
		`CHK({resp, rdat}, {ros_pkg::AXI_SLVERR, 32'h0000_0000});
		wr(ros_pkg::OFS_STAT, 32'h0000_00FF);
		`CHK(resp, ros_pkg::AXI_OKAY);
		wZero <= 1'b1;
		wr(ros_pkg::OFS_FUNC, 32'h0000_0002);
		for (int i = 0; i < 6; i++) begin
			sel = (i == 0) ? 3'h5 : 3'($urandom);
			pat = (i == 0) ? 3'h2 : 3'($urandom);
			dem = 3'($urandom);
			wr(ros_pkg::OFS_CTRL, {25'h0, pat, 1'b0, sel});
			wDem <= dem;
			wPins <= 3'h1;
			cyc(30);
			`CHK(relays, (dem & ~sel) | (pat & sel));
			wPins <= 3'h0;
			cyc(30);
			`CHK(relays, dem);
		end
		wr(ros_pkg::OFS_FUNC, 32'h0000_0200);
		wr(ros_pkg::OFS_CTRL, 32'h0000_0008);
		dem = 3'($urandom);
		wDem <= dem;
		cyc(30);
		wPins <= 3'h2;
		cyc(30);
		wDem <= ~dem;
		cyc(2600);
		`CHK(relays, dem);
		`CHK(pulses, 1);
		`CHK(cmdAlarm, 1'b0);
		rd(ros_pkg::OFS_STAT);
		`CHK(rdat, {24'h00_0000, 5'b01000, dem});
		wPins <= 3'h0;
		cyc(30);
		`CHK(relays, ~dem);
		wr(ros_pkg::OFS_CTRL, 32'h0000_0000);
		wr(ros_pkg::OFS_MODE, 32'h0000_0004);
		wr(ros_pkg::OFS_TIME, 32'h0005_0002);
		wr(ros_pkg::OFS_FUNC, 32'h000C_0000);
		{wDem, wZero, wStill} <= 5'h00;
		wPins <= 3'h4;
		cyc(40);
		`CHK({motionDisabled, cmdAlarm}, 2'b00);
		wZero <= 1'b1;
		cyc(40);
		`CHK({cmdAlarm, relays}, 4'b1010);
		wPins <= 3'h0;
		wZero <= 1'b0;
		cyc(18);
		`CHK({motionDisabled, cmdAlarm}, 2'b10);
		cyc(40);
		`CHK({cmdAlarm, relays}, 4'b1010);
		rd(ros_pkg::OFS_STAT);
		`CHK(rdat[7:0], 8'h32);
		wStill <= 1'b1;
		cyc(5);
		`CHK(cmdAlarm, 1'b0);
		wr(ros_pkg::OFS_CTRL, 32'h0000_0100);
		cyc(5);
		`CHK(motionDisabled, 1'b0);
		results();
	end
endmodule // test_relay_override_motion_supervisor
`default_nettype wire
